// file: logic/kbd_enc_pkg.sv
// Purpose: Shared constants for the keyboard encoder host handshake block
// Assumes: Single 20 MHz system clock, synchronous active-low reset
// Notes: Debounce intervals are counted in scan-strobe periods
package kbd_enc_pkg;

    // Key matrix geometry
    localparam int DRIVE_COUNT = 11;
    localparam int SENSE_COUNT = 8;
    localparam int SCAN_W = 7;
    localparam int CODE_W = 8;
    localparam int SEL_W = 4;
    localparam logic [SCAN_W-1:0] SCAN_LAST = 7'h57;
    localparam logic [SCAN_W-1:0] SCAN_RESET = 7'h00;

    // Select pattern that marks the encoder as addressed
    localparam logic [SEL_W-1:0] SEL_MATCH = 4'hf;

    // Debounce counts in strobe periods
    localparam int CLOSE_DEB_STROBES = 2;
    localparam int RELEASE_DEB_STROBES = 4;
    localparam int DEB_W = 8;

    // Flag reset values (both flags idle high)
    localparam logic FLAG_IDLE = 1'b1;

    // Handshake states
    typedef enum logic [1:0] {
        ST_SCAN = 2'b00,
        ST_DEB_CLOSE = 2'b01,
        ST_HELD = 2'b10,
        ST_RELEASED = 2'b11
    } kbd_state_t;

endpackage

// file: logic/kbd_encoder.sv
// Purpose: Matrix keyboard encoder core with host flag handshake
// Assumes: Scan strobe, selects and sense lines arrive asynchronously
// Notes: All actions except the bus enable keyed to synchronised strobe edges
`timescale 1ns/1ps
module kbd_encoder
    import kbd_enc_pkg::*;
#(
    parameter int CLOSE_STROBES = CLOSE_DEB_STROBES,
    parameter int RELEASE_STROBES = RELEASE_DEB_STROBES
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic SCAN_STROBE,
    input wire logic [SEL_W-1:0] SELECT_INPUTS,
    input wire logic [SENSE_COUNT-1:0] SENSE_LINES,
    output logic [DRIVE_COUNT-1:0] DRIVE_LINES,
    output logic [CODE_W-1:0] DATA_OUT,
    output logic DATA_OE,
    output logic KEY_AVAILABLE_N,
    output logic KEY_REPEAT_N
);

    logic strobe_lvl; // Synchronised strobe level
    logic strobe_rise; // Strobe low-to-high event
    logic strobe_fall; // Strobe high-to-low event
    logic [SEL_W-1:0] sel_lvl; // Synchronised selects
    logic [SENSE_COUNT-1:0] sense_lvl; // Synchronised sense lines
    logic selected; // Encoder addressed by host
    logic key_closed; // Key at current scan position closed
    logic scan_run; // Scan counter may advance
    logic close_done; // Closure debounce finished this edge
    logic release_done; // Release debounce finished this edge
    logic host_clear; // Selected rising strobe
    kbd_state_t state_ff; // Handshake state
    kbd_state_t nxt_state; // Next handshake state
    logic [DEB_W-1:0] deb_ff; // Debounce period counter
    logic [SCAN_W-1:0] scan_ff; // Scan position
    logic [SCAN_W-1:0] nxt_scan; // Next scan position
    logic [DRIVE_COUNT-1:0] drive_ff; // Registered drive lines
    logic [CODE_W-1:0] code_ff; // Latched key code
    logic key_available_n_ff; // Available flag, low active
    logic key_repeat_n_ff; // Repeat flag, low active
    logic oe_ff; // Registered bus enable

    // Strobe synchroniser
    pin_sync #(.W(1)) u_strobe_sync (
        .CLK(CLK),
        .RST_N(RST_N),
        .PIN(SCAN_STROBE),
        .LEVEL(strobe_lvl),
        .RISE(strobe_rise),
        .FALL(strobe_fall)
    );

    // Select synchroniser
    pin_sync #(.W(SEL_W)) u_sel_sync (
        .CLK(CLK),
        .RST_N(RST_N),
        .PIN(SELECT_INPUTS),
        .LEVEL(sel_lvl),
        .RISE(),
        .FALL()
    );

    // Sense line synchroniser
    pin_sync #(.W(SENSE_COUNT)) u_sense_sync (
        .CLK(CLK),
        .RST_N(RST_N),
        .PIN(SENSE_LINES),
        .LEVEL(sense_lvl),
        .RISE(),
        .FALL()
    );

    // Decode and status terms
    assign selected = (sel_lvl == SEL_MATCH);
    assign key_closed = sense_lvl[scan_ff[2:0]];
    assign host_clear = strobe_rise && selected;
    assign close_done = (deb_ff == DEB_W'(CLOSE_STROBES - 1)) && key_closed;
    assign release_done = (deb_ff == DEB_W'(RELEASE_STROBES - 1)) && !key_closed;
    // Counter frozen once a key is caught, unless host toggles while selected
    assign scan_run = (state_ff == ST_SCAN) || selected;

    // Next handshake state, evaluated on rising strobe
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_SCAN: begin
                if (key_closed) begin
                    nxt_state = ST_DEB_CLOSE;
                end
            end
            ST_DEB_CLOSE: begin
                if (!key_closed) begin
                    nxt_state = ST_SCAN; // Bounce, resume scanning
                end else if (close_done) begin
                    nxt_state = ST_HELD;
                end
            end
            ST_HELD: begin
                if (release_done) begin
                    nxt_state = ST_RELEASED;
                end
            end
            default: begin
                // Wait for host to read before scanning again
                if (key_available_n_ff && !host_clear) begin
                    nxt_state = ST_SCAN;
                end else if (host_clear) begin
                    nxt_state = ST_SCAN;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state_ff <= ST_SCAN;
        end else if (strobe_rise) begin
            state_ff <= nxt_state;
        end
    end

    // Debounce counter, counts strobe periods
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            deb_ff <= '0;
        end else if (strobe_rise) begin
            if (nxt_state != state_ff) begin
                deb_ff <= '0;
            end else if (state_ff == ST_HELD && key_closed) begin
                deb_ff <= '0; // Key still down, restart release timing
            end else if (state_ff == ST_DEB_CLOSE || state_ff == ST_HELD) begin
                deb_ff <= deb_ff + DEB_W'(1);
            end
        end
    end

    // Next scan position, wraps after last key
    always_comb begin
        nxt_scan = scan_ff;
        if (strobe_fall && scan_run) begin
            if (scan_ff == SCAN_LAST) begin
                nxt_scan = SCAN_RESET;
            end else begin
                nxt_scan = scan_ff + SCAN_W'(1);
            end
        end
    end

    // Scan counter and drive lines
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            scan_ff <= SCAN_RESET;
            drive_ff <= '0;
        end else begin
            scan_ff <= nxt_scan;
            drive_ff <= '0;
            drive_ff[nxt_scan[SCAN_W-1:3]] <= 1'b1;
        end
    end

    // Available flag; set wins over a coincident clear
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            key_available_n_ff <= FLAG_IDLE;
        end else if (strobe_rise && state_ff == ST_DEB_CLOSE && close_done) begin
            key_available_n_ff <= 1'b0;
        end else if (host_clear) begin
            key_available_n_ff <= FLAG_IDLE;
        end
    end

    // Key code latched with the flag
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            code_ff <= '0;
        end else if (strobe_rise && state_ff == ST_DEB_CLOSE && close_done) begin
            code_ff <= {1'b0, scan_ff};
        end
    end

    // Repeat flag
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            key_repeat_n_ff <= FLAG_IDLE;
        end else if (strobe_rise && state_ff == ST_HELD && release_done) begin
            key_repeat_n_ff <= FLAG_IDLE;
        end else if (host_clear && state_ff == ST_HELD && key_closed) begin
            key_repeat_n_ff <= 1'b0;
        end
    end

    // Bus enable follows select
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            oe_ff <= 1'b0;
        end else begin
            oe_ff <= selected;
        end
    end

    // Outputs
    assign DRIVE_LINES = drive_ff;
    assign DATA_OUT = code_ff;
    assign DATA_OE = oe_ff;
    assign KEY_AVAILABLE_N = key_available_n_ff;
    assign KEY_REPEAT_N = key_repeat_n_ff;

    // Checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    sequence sel_rise_s;
        strobe_rise && selected;
    endsequence

    sequence close_end_s;
        strobe_rise && state_ff == ST_DEB_CLOSE && close_done;
    endsequence

    sequence release_end_s;
        strobe_rise && state_ff == ST_HELD && release_done;
    endsequence

    flag_set_a: assert property (close_end_s |=> !KEY_AVAILABLE_N)
        else $error("Available flag not set after closure debounce");
    flag_clear_a: assert property (sel_rise_s and !close_done |=> KEY_AVAILABLE_N)
        else $error("Available flag not cleared by selected strobe");
    debounce_start_a: assert property (strobe_rise && state_ff == ST_SCAN && key_closed
        |=> state_ff == ST_DEB_CLOSE && deb_ff == 0)
        else $error("Closure debounce did not start");
    scan_resume_a: assert property (state_ff == ST_SCAN && strobe_fall
        |=> scan_ff != $past(scan_ff))
        else $error("Scan counter did not advance");
    scan_hold_a: assert property (!KEY_AVAILABLE_N && !selected && strobe_fall
        |=> $stable(scan_ff))
        else $error("Scan counter moved while flag active");
    lockout_hold_a: assert property (state_ff != ST_SCAN && !selected
        |=> $stable(scan_ff))
        else $error("Scan counter moved during key lockout");
    sel_toggle_a: assert property (selected && strobe_fall
        |=> scan_ff != $past(scan_ff))
        else $error("Selected strobe did not clock counter");
    repeat_set_a: assert property (sel_rise_s and state_ff == ST_HELD && key_closed
        |=> !KEY_REPEAT_N [*2])
        else $error("Repeat flag not raised on read with key down");
    repeat_clear_a: assert property (release_end_s |=> KEY_REPEAT_N)
        else $error("Repeat flag not cleared after release");
    no_reflag_a: assert property ($fell(KEY_AVAILABLE_N)
        |-> $past(state_ff) == ST_DEB_CLOSE)
        else $error("Flag set again without new closure");
    bus_enable_a: assert property (DATA_OE |-> $past(selected))
        else $error("Bus driven while not selected");

endmodule

// file: logic/pin_sync.sv
// Purpose: Two-stage synchroniser with edge detect for pin inputs
// Assumes: Inputs are asynchronous to CLK
// Notes: First stage feeds only the second stage; hold reset at least two cycles
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [W-1:0] PIN,
    output logic [W-1:0] LEVEL,
    output logic [W-1:0] RISE,
    output logic [W-1:0] FALL
);

    logic [W-1:0] meta_ff; // First stage, read by second stage only
    logic [W-1:0] sync_ff; // Second stage, safe to use
    logic [W-1:0] prev_ff; // Delayed copy for edge detection
    logic armed_ff; // Edges reported only once the history is real

    // Synchroniser chain keeps sampling through reset, so its history
    // matches the pin and a pin that idles high gives no false edge
    always_ff @(posedge CLK) begin
        meta_ff <= PIN;
        sync_ff <= meta_ff;
        prev_ff <= sync_ff;
    end

    // Edge report enable, low during reset
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            armed_ff <= 1'b0;
        end else begin
            armed_ff <= 1'b1;
        end
    end

    // Level and edge outputs
    assign LEVEL = sync_ff;
    assign RISE = sync_ff & ~prev_ff & {W{armed_ff}};
    assign FALL = ~sync_ff & prev_ff & {W{armed_ff}};

endmodule

// file: tb/host_model.sv
// Purpose: Host processor model that makes the scan strobe and selects
// Assumes: 64-clock strobe period, half high and half low
// Notes: Strobe is forced high while selected unless TOGGLE is set, like a NAND glue gate
`timescale 1ns/1ps
module host_model
    import kbd_enc_pkg::*;
(
    input wire logic CLK,
    input wire logic RD_REQ,
    input wire logic TOGGLE,
    output logic SCAN_STROBE,
    output logic [SEL_W-1:0] SELECT_INPUTS
);
    logic [5:0] phase_ff = 6'h00; // Strobe phase, 64 clocks a period
    logic sel_ff = 1'b0; // Encoder selected for an input cycle

    // Free-running phase gives 312.5 kHz at 20 MHz
    always @(negedge CLK) begin
        phase_ff <= phase_ff + 6'h01;
    end

    // Select only for a requested read, opened 8 clocks into the low phase,
    // closed in the high phase; a toggling host keeps it while asked
    always @(negedge CLK) begin
        if (phase_ff == 6'h28 && RD_REQ) begin
            sel_ff <= 1'b1;
        end else if (phase_ff == 6'h00 && !(TOGGLE && RD_REQ)) begin
            sel_ff <= 1'b0;
        end
    end

    // Strobe held high whenever selected, unless a faulty host lets it run
    assign SCAN_STROBE = (phase_ff < 6'h20) | (sel_ff & ~TOGGLE);
    assign SELECT_INPUTS = sel_ff ? SEL_MATCH : 4'h0;
endmodule

// file: tb/testbench.sv
// Purpose: Self-checking bench for the keyboard encoder handshake
// Assumes: Inputs change at the falling clock edge
// Notes: Key matrix is modelled here from the drive lines
`timescale 1ns/1ps
module testbench
    import kbd_enc_pkg::*;
;
    localparam int WAIT_MAX = 7000; // Full scan plus debounce
    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    logic rd_req = 1'b0; // Ask host model for a read
    logic toggle = 1'b0; // Host lets the strobe run while selected
    logic [DRIVE_COUNT*SENSE_COUNT-1:0] keys = '0; // Closed keys by code
    logic SCAN_STROBE;
    logic [SEL_W-1:0] SELECT_INPUTS;
    logic [SENSE_COUNT-1:0] sense;
    logic [DRIVE_COUNT-1:0] DRIVE_LINES;
    logic [CODE_W-1:0] DATA_OUT;
    logic DATA_OE;
    logic KEY_AVAILABLE_N;
    logic KEY_REPEAT_N;
    int num_errors = 0;
    int n_checks = 0;
    int cycles = 0;

    kbd_encoder #(.CLOSE_STROBES(2), .RELEASE_STROBES(4)) dut (.CLK(CLK), .RST_N(RST_N),
        .SCAN_STROBE(SCAN_STROBE), .SELECT_INPUTS(SELECT_INPUTS), .SENSE_LINES(sense),
        .DRIVE_LINES(DRIVE_LINES), .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE),
        .KEY_AVAILABLE_N(KEY_AVAILABLE_N), .KEY_REPEAT_N(KEY_REPEAT_N));

    host_model host (.CLK(CLK), .RD_REQ(rd_req), .TOGGLE(toggle), .SCAN_STROBE(SCAN_STROBE),
        .SELECT_INPUTS(SELECT_INPUTS));

    // Closed switch links its drive line to its sense line
    always_comb begin
        sense = '0;
        for (int c = 0; c < DRIVE_COUNT; c++)
            for (int s = 0; s < SENSE_COUNT; s++)
                if (DRIVE_LINES[c] && keys[c*SENSE_COUNT+s]) sense[s] = 1'b1;
    end

    initial forever #25 CLK = ~CLK;

    task automatic stop_test();
        $display("Counts: %0d checks, %0d mismatches", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 30000) begin
            num_errors++;
            stop_test();
        end
    end

    task automatic chk_bit(input string what, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chk_code(input string what, input logic [CODE_W-1:0] exp,
        input logic [CODE_W-1:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Wait, bounded, for a flag to reach a level
    task automatic wait_flag(input bit key_repeat_n, input logic v);
        int n;
        n = 0;
        while ((key_repeat_n ? KEY_REPEAT_N : KEY_AVAILABLE_N) !== v && n < WAIT_MAX) begin
            @(negedge CLK);
            n++;
        end
    endtask

    // One host input cycle through the host model
    task automatic host_read(input logic [CODE_W-1:0] code, input logic key_repeat_n);
        rd_req <= 1'b1;
        for (int n = 0; n < 100 && DATA_OE !== 1'b1; n++) @(negedge CLK);
        rd_req <= 1'b0;
        chk_bit("data_oe", 1'b1, DATA_OE);
        chk_code("data_out", code, DATA_OUT);
        repeat (8) @(negedge CLK);
        chk_bit("avail", 1'b1, KEY_AVAILABLE_N);
        chk_bit("repeat", key_repeat_n, KEY_REPEAT_N);
        for (int n = 0; n < 100 && DATA_OE !== 1'b0; n++) @(negedge CLK);
        chk_bit("data_oe", 1'b0, DATA_OE);
    endtask

    task automatic test_idle();
        repeat (200) @(negedge CLK);
        chk_bit("avail", 1'b1, KEY_AVAILABLE_N);
        chk_bit("data_oe", 1'b0, DATA_OE);
        $display("test_idle done");
    endtask

    // Held key, second key during hold, repeat, release, resume
    task automatic test_repeat();
        logic [DRIVE_COUNT-1:0] d;
        keys[8'h1a] <= 1'b1;
        wait_flag(0, 1'b0);
        chk_bit("avail", 1'b0, KEY_AVAILABLE_N);
        chk_code("data_out", 8'h1a, DATA_OUT);
        d = DRIVE_LINES;
        keys[8'h57] <= 1'b1;
        repeat (256) @(negedge CLK);
        chk_bit("scan_halt", 1'b1, DRIVE_LINES === d);
        chk_code("data_out", 8'h1a, DATA_OUT);
        host_read(8'h1a, 1'b0);
        repeat (512) @(negedge CLK);
        chk_bit("avail", 1'b1, KEY_AVAILABLE_N);
        keys[8'h1a] <= 1'b0;
        repeat (64) @(negedge CLK);
        chk_bit("repeat", 1'b0, KEY_REPEAT_N);
        wait_flag(1, 1'b1);
        chk_bit("repeat", 1'b1, KEY_REPEAT_N);
        wait_flag(0, 1'b0);
        chk_code("data_out", 8'h57, DATA_OUT);
        $display("test_repeat done");
    endtask

    // Key released before the read: no repeat, no new flag
    task automatic test_no_repeat();
        keys[8'h57] <= 1'b0;
        repeat (512) @(negedge CLK);
        host_read(8'h57, 1'b1);
        repeat (512) @(negedge CLK);
        chk_bit("avail", 1'b1, KEY_AVAILABLE_N);
        $display("test_no_repeat done");
    endtask

    // Strobe left running while selected: flag held clear, scan moves on
    task automatic test_sel_toggle();
        logic [DRIVE_COUNT-1:0] d;
        keys[8'h07] <= 1'b1;
        wait_flag(0, 1'b0);
        chk_code("data_out", 8'h07, DATA_OUT);
        d = DRIVE_LINES;
        toggle <= 1'b1;
        rd_req <= 1'b1;
        for (int n = 0; n < 100 && DATA_OE !== 1'b1; n++) @(negedge CLK);
        chk_bit("data_oe", 1'b1, DATA_OE);
        repeat (200) @(negedge CLK);
        chk_bit("avail", 1'b1, KEY_AVAILABLE_N);
        chk_bit("scan_moved", 1'b0, DRIVE_LINES === d);
        while (SCAN_STROBE !== 1'b1) @(negedge CLK);
        rd_req <= 1'b0;
        toggle <= 1'b0;
        for (int n = 0; n < 100 && DATA_OE !== 1'b0; n++) @(negedge CLK);
        chk_bit("data_oe", 1'b0, DATA_OE);
        keys[8'h07] <= 1'b0;
        repeat (512) @(negedge CLK);
        chk_bit("avail", 1'b1, KEY_AVAILABLE_N);
        $display("test_sel_toggle done");
    endtask

    initial begin
        repeat (2) @(negedge CLK);
        RST_N <= 1'b1;
        test_idle();
        test_repeat();
        test_no_repeat();
        test_sel_toggle();
        stop_test();
    end
endmodule
